// file: logic/shp_pkg.sv
// shared constants and types of the sensor hub host protocol framer
package shp_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int US_CYCLES = CLK_HZ / 1_000_000;
    localparam int T_INIT_MS = 90;
    localparam int INIT_CYCLES = (CLK_HZ / 1000) * T_INIT_MS;
    localparam int VS_PERIOD_US = 10000;

    // ------------------------------------------------------------
    // transport header and channels
    // ------------------------------------------------------------
    localparam logic [4:0] HDR_BYTES = 5'd4;
    localparam logic [7:0] CH_CTRL = 8'h00;
    localparam logic [7:0] CH_EXEC = 8'h01;
    localparam logic [7:0] CH_HUB = 8'h02;
    localparam logic [7:0] CH_INPUT = 8'h03;

    // ------------------------------------------------------------
    // report ids and command layout
    // ------------------------------------------------------------
    localparam logic [7:0] RID_SET_FEATURE = 8'hfd;
    localparam logic [7:0] RID_FEATURE_RESP = 8'hfc;
    localparam logic [7:0] RID_TIMEBASE = 8'hfb;
    localparam logic [7:0] RID_ACCEL = 8'h01;
    localparam logic [7:0] LEN_SET_FEATURE = 8'h15;
    localparam logic [7:0] SF_POS_ID = 8'h04;
    localparam logic [7:0] SF_POS_SENSOR = 8'h05;
    localparam logic [7:0] SF_POS_INT0 = 8'h09;
    localparam logic [7:0] SF_POS_INT3 = 8'h0c;
    localparam logic [7:0] VS_SYNC = 8'haa;

    // ------------------------------------------------------------
    // packet lengths, header included where framed
    // ------------------------------------------------------------
    localparam logic [4:0] LEN_BANNER = 5'd24;
    localparam logic [4:0] LEN_ADV = 5'd12;
    localparam logic [4:0] LEN_RST = 5'd5;
    localparam logic [4:0] LEN_INIT = 5'd8;
    localparam logic [4:0] LEN_FRESP = 5'd21;
    localparam logic [4:0] LEN_ACCEL = 5'd19;
    localparam logic [4:0] LEN_VS = 5'd10;

    // ------------------------------------------------------------
    // message store layout
    // ------------------------------------------------------------
    localparam int ROM_AW = 6;
    localparam logic [5:0] ROM_BANNER = 6'h00;
    localparam logic [5:0] ROM_ADV = 6'h18;
    localparam logic [5:0] ROM_RST = 6'h20;
    localparam logic [5:0] ROM_INIT = 6'h24;

    // ------------------------------------------------------------
    // periods the physical accelerometer supports, ascending
    // ------------------------------------------------------------
    localparam int N_RATES = 7;
    localparam logic [31:0] RATE_US [N_RATES] = '{32'h0000_09c4, 32'h0000_1388,
        32'h0000_2710, 32'h0000_4e20, 32'h0000_9c40, 32'h0001_3880, 32'h0002_7100};

    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_IDLE = 3'b001,
        ST_ATTN = 3'b010,
        ST_FETCH = 3'b011,
        ST_ROMW = 3'b100,
        ST_PUT = 3'b101,
        ST_HOLD = 3'b110
    } shp_state_t;

    typedef enum logic [2:0] {
        K_BANNER = 3'b000,
        K_VS = 3'b001,
        K_ADV = 3'b010,
        K_RST = 3'b011,
        K_INIT = 3'b100,
        K_FRESP = 3'b101,
        K_ACCEL = 3'b110
    } shp_kind_t;

endpackage : shp_pkg

// file: logic/shp_rom_if.sv
// carrier between the framer core and its message store
`timescale 1ns/10ps
`default_nettype none
interface shp_rom_if;
    logic [shp_pkg::ROM_AW-1:0] addr;
    logic [7:0] data;
    modport core (output addr, input data);
    modport mem (input addr, output data);
endinterface : shp_rom_if
`default_nettype wire

// file: logic/shp_rom.sv
// fixed message store: banner text and startup message payloads
`timescale 1ns/10ps
`default_nettype none
module shp_rom (
    input wire logic mclk,
    shp_rom_if.mem rom
);
    import shp_pkg::*;

    // ------------------------------------------------------------
    // contents
    // ------------------------------------------------------------
    // version text is arbitrary, no maker or part named
    localparam logic [8*24-1:0] BANNER = "%sensor hub SW Ver 3.2\r\n";

    logic [7:0] data_reg;
    logic [7:0] data_next;

    // lookup of one byte; payloads follow the header, which the core builds
    always_comb begin
        data_next = 8'h00;
        if (rom.addr < ROM_ADV) begin
            data_next = BANNER[(23 - int'(rom.addr)) * 8 +: 8];
        end else begin
            case (rom.addr)
                6'h18: data_next = 8'h00; // advert: channel table tag
                6'h19: data_next = 8'h04; // channels in use
                6'h1a: data_next = 8'h01;
                6'h1b: data_next = 8'h02;
                6'h1c: data_next = 8'h03; // max packet length tag
                6'h1d: data_next = 8'h15;
                6'h1e: data_next = 8'h00;
                6'h1f: data_next = 8'h00;
                6'h20: data_next = 8'h01; // reset complete
                6'h24: data_next = 8'hf1; // unsolicited init
                6'h25: data_next = 8'h00;
                6'h26: data_next = 8'h04;
                6'h27: data_next = 8'h00;
                default: data_next = 8'h00;
            endcase
        end
    end

    // registered read keeps the store timing independent of the decode
    always_ff @(posedge mclk) begin
        data_reg <= data_next;
    end

    assign rom.data = data_reg;

endmodule : shp_rom
`default_nettype wire

// file: logic/shp_framer.sv
// sensor hub host protocol framer: startup, command parse and report framing
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RQ1: vector mode: banner, then periodic vector packets
// RQ2: other modes: sensors off until host configures
// RQ3: attention asserted once startup wait ends
// RQ4: first packet is the advertisement
// RQ5: reset-complete message follows on channel 1
// RQ6: init message follows on channel 2
// RQ7: then idle until host enables a function
// RQ8: header: length low, high, channel, sequence
// RQ9: host set-feature: ch 2, len 0x15, 0xfd
// RQ10: feature response gives the granted period
// RQ11: granted period rounds to supported sensor rates
// RQ12: reports follow the granted period
// RQ13: period change sends unsolicited feature response
// RQ14: timebase record 0xfb precedes each report
// RQ15: accel report id 0x01 on channel 3
// RQ16: attention held until host addresses device
// RQ17: sequence number per channel increments mod 256
module shp_framer #(
    parameter int STARTUP_CYCLES = shp_pkg::INIT_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic mode_strap,
    input wire logic host_addressed,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic host_attention_n,
    input wire logic accel_valid,
    input wire logic [15:0] accel_x,
    input wire logic [15:0] accel_y,
    input wire logic [15:0] accel_z,
    input wire logic [7:0] accel_status,
    output logic sensor_enabled
);
    import shp_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        shp_state_t state;
        shp_kind_t kind;
        logic [4:0] idx;
        logic [4:0] len;
        logic [31:0] wait_cnt;
        logic [5:0] us_div;
        logic [31:0] tmr;
        logic [31:0] vs_tmr;
        logic p_banner;
        logic p_vs;
        logic p_adv;
        logic p_rst;
        logic p_init;
        logic p_fresp;
        logic p_accel;
        logic serial_mode;
        logic en;
        logic [31:0] period;
        logic [3:0][7:0] seq;
        logic [7:0] rx_cnt;
        logic [7:0] rx_len;
        logic [7:0] rx_ch;
        logic [7:0] rx_id;
        logic [7:0] rx_sens;
        logic [31:0] rx_int;
        logic [47:0] smp;
        logic [7:0] smp_status;
        logic [31:0] delta;
        logic [31:0] delta_snap;
        logic [7:0] rep_seq;
        logic [7:0] vs_idx;
        logic [7:0] tx_data;
        logic tx_valid;
        logic attn;
        logic [2:0] as_sync;
        logic [2:0] ms_sync;
        logic addr_lvl;
        logic [5:0] rom_addr;
    } shp_regs_t;

    shp_regs_t r_reg;
    shp_regs_t r_next;
    shp_rom_if rom_bus ();

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // smallest supported period not below the request, largest if the request exceeds it, 0 disables
    function automatic logic [31:0] grant_period(input logic [31:0] req);
        logic [31:0] g;
        g = RATE_US[N_RATES-1];
        if (req == 32'h0) begin
            g = 32'h0;
        end else begin
            for (int i = N_RATES - 1; i >= 0; i--) begin
                if (req <= RATE_US[i]) begin
                    g = RATE_US[i];
                end
            end
        end
        return g;
    endfunction : grant_period

    function automatic logic [7:0] chan_of(input shp_kind_t k);
        logic [7:0] c;
        case (k)
            K_ADV: c = CH_CTRL;
            K_RST: c = CH_EXEC;
            K_INIT: c = CH_HUB;
            K_FRESP: c = CH_HUB;
            default: c = CH_INPUT;
        endcase
        return c;
    endfunction : chan_of

    logic [7:0] cur_byte;
    logic [7:0] vs_sum;
    logic framed;
    logic last_byte;
    logic addr_edge;
    logic rx_end;
    logic sf_ok;

    // ------------------------------------------------------------
    // packet byte selection
    // ------------------------------------------------------------
    always_comb begin
        framed = (r_reg.kind != K_BANNER) && (r_reg.kind != K_VS);
        vs_sum = r_reg.vs_idx + r_reg.smp[7:0] + r_reg.smp[15:8] + r_reg.smp[23:16]
            + r_reg.smp[31:24] + r_reg.smp[39:32] + r_reg.smp[47:40];
        cur_byte = rom_bus.data;
        if (r_reg.kind == K_VS) begin
            case (r_reg.idx)
                5'd0, 5'd1: cur_byte = VS_SYNC;
                5'd2: cur_byte = r_reg.vs_idx;
                5'd9: cur_byte = vs_sum;
                default: cur_byte = r_reg.smp[(int'(r_reg.idx) - 3) * 8 +: 8];
            endcase
        end else if (framed && r_reg.idx < HDR_BYTES) begin
            case (r_reg.idx[1:0])
                2'd0: cur_byte = {3'b000, r_reg.len}; // RQ8
                2'd1: cur_byte = 8'h00; // RQ8
                2'd2: cur_byte = chan_of(r_reg.kind); // RQ8
                default: cur_byte = r_reg.seq[chan_of(r_reg.kind)]; // RQ8
            endcase
        end else if (r_reg.kind == K_FRESP) begin
            case (r_reg.idx)
                5'd4: cur_byte = RID_FEATURE_RESP; // RQ10
                5'd5: cur_byte = RID_ACCEL;
                5'd9, 5'd10, 5'd11, 5'd12: cur_byte = r_reg.period[(int'(r_reg.idx) - 9) * 8 +: 8]; // RQ10
                default: cur_byte = 8'h00;
            endcase
        end else if (r_reg.kind == K_ACCEL) begin
            case (r_reg.idx)
                5'd4: cur_byte = RID_TIMEBASE; // RQ14
                5'd5, 5'd6, 5'd7, 5'd8: cur_byte = r_reg.delta_snap[(int'(r_reg.idx) - 5) * 8 +: 8]; // RQ14
                5'd9: cur_byte = RID_ACCEL; // RQ15
                5'd10: cur_byte = r_reg.rep_seq; // RQ15
                5'd11: cur_byte = r_reg.smp_status; // RQ15
                5'd12: cur_byte = 8'h00; // RQ15
                default: cur_byte = r_reg.smp[(int'(r_reg.idx) - 13) * 8 +: 8]; // RQ15
            endcase
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        last_byte = (r_reg.idx == r_reg.len - 5'd1);
        // address change counts only once second and third stages agree
        r_next.as_sync = {r_reg.as_sync[1:0], host_addressed};
        r_next.ms_sync = {r_reg.ms_sync[1:0], mode_strap};
        if (r_reg.as_sync[1] == r_reg.as_sync[2]) begin
            r_next.addr_lvl = r_reg.as_sync[2];
        end
        addr_edge = r_next.addr_lvl && !r_reg.addr_lvl;

        // command receiver: length from the header bounds each packet
        rx_end = 1'b0;
        sf_ok = 1'b0;
        if (rx_valid) begin
            r_next.rx_cnt = r_reg.rx_cnt + 8'd1;
            case (r_reg.rx_cnt)
                8'h00: r_next.rx_len = rx_data;
                8'h02: r_next.rx_ch = rx_data;
                SF_POS_ID: r_next.rx_id = rx_data;
                SF_POS_SENSOR: r_next.rx_sens = rx_data;
                default: ;
            endcase
            if (r_reg.rx_cnt >= SF_POS_INT0 && r_reg.rx_cnt <= SF_POS_INT3) begin
                r_next.rx_int[(int'(r_reg.rx_cnt) - 9) * 8 +: 8] = rx_data; // RQ9
            end
            rx_end = (r_reg.rx_cnt >= 8'd3) && (r_reg.rx_cnt + 8'd1 >= r_reg.rx_len);
            if (rx_end) begin
                r_next.rx_cnt = 8'd0;
            end
        end
        // only the accelerometer is served; other ids are dropped
        sf_ok = rx_end && r_reg.rx_ch == CH_HUB && r_reg.rx_len == LEN_SET_FEATURE // RQ9
            && r_reg.rx_id == RID_SET_FEATURE && r_reg.rx_sens == RID_ACCEL
            && !r_reg.serial_mode;
        case (r_reg.state)
            ST_BOOT: begin
                r_next.wait_cnt = r_reg.wait_cnt + 32'd1;
                if (r_reg.wait_cnt >= 32'(STARTUP_CYCLES - 1)
                    && r_reg.ms_sync[1] == r_reg.ms_sync[2]) begin
                    r_next.serial_mode = r_reg.ms_sync[2];
                    r_next.p_banner = r_reg.ms_sync[2]; // RQ1
                    r_next.p_adv = !r_reg.ms_sync[2]; // RQ4
                    r_next.p_rst = !r_reg.ms_sync[2]; // RQ5
                    r_next.p_init = !r_reg.ms_sync[2]; // RQ6
                    r_next.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // fixed priority keeps the startup order of the messages
                r_next.idx = 5'd0;
                r_next.state = ST_ATTN;
                r_next.attn = 1'b1; // RQ3
                if (r_reg.p_banner) begin
                    r_next.p_banner = 1'b0;
                    r_next.kind = K_BANNER;
                    r_next.len = LEN_BANNER;
                    r_next.state = ST_FETCH;
                    r_next.attn = 1'b0;
                end else if (r_reg.p_vs) begin
                    r_next.p_vs = 1'b0;
                    r_next.kind = K_VS;
                    r_next.len = LEN_VS;
                    r_next.state = ST_FETCH;
                    r_next.attn = 1'b0;
                end else if (r_reg.p_adv) begin
                    r_next.p_adv = 1'b0; // RQ4
                    r_next.kind = K_ADV;
                    r_next.len = LEN_ADV;
                end else if (r_reg.p_rst) begin
                    r_next.p_rst = 1'b0; // RQ5
                    r_next.kind = K_RST;
                    r_next.len = LEN_RST;
                end else if (r_reg.p_init) begin
                    r_next.p_init = 1'b0; // RQ6
                    r_next.kind = K_INIT;
                    r_next.len = LEN_INIT;
                end else if (r_reg.p_fresp && !sf_ok) begin
                    r_next.p_fresp = 1'b0;
                    r_next.kind = K_FRESP;
                    r_next.len = LEN_FRESP;
                end else if (r_reg.p_accel && r_reg.en && !sf_ok) begin
                    r_next.p_accel = 1'b0; // RQ2
                    r_next.kind = K_ACCEL;
                    r_next.len = LEN_ACCEL;
                    r_next.delta_snap = r_reg.delta;
                end else begin
                    r_next.state = ST_IDLE; // RQ7
                    r_next.attn = 1'b0;
                end
            end
            ST_ATTN: begin
                // line stays low until the host addresses us
                if (addr_edge) begin
                    r_next.attn = 1'b0; // RQ16
                    r_next.state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                case (r_reg.kind)
                    K_ADV: r_next.rom_addr = ROM_ADV + 6'(r_reg.idx - HDR_BYTES);
                    K_RST: r_next.rom_addr = ROM_RST + 6'(r_reg.idx - HDR_BYTES);
                    K_INIT: r_next.rom_addr = ROM_INIT + 6'(r_reg.idx - HDR_BYTES);
                    default: r_next.rom_addr = ROM_BANNER + 6'(r_reg.idx);
                endcase
                r_next.state = ST_ROMW;
            end
            ST_ROMW: begin
                r_next.state = ST_PUT;
            end
            ST_PUT: begin
                r_next.tx_data = cur_byte;
                r_next.tx_valid = 1'b1;
                r_next.state = ST_HOLD;
            end
            ST_HOLD: begin
                if (tx_ready) begin
                    r_next.tx_valid = 1'b0;
                    r_next.idx = r_reg.idx + 5'd1;
                    r_next.state = ST_FETCH;
                    if (last_byte) begin
                        r_next.state = ST_IDLE;
                        if (framed) begin
                            r_next.seq[chan_of(r_reg.kind)] =
                                r_reg.seq[chan_of(r_reg.kind)] + 8'd1; // RQ17
                        end
                        if (r_reg.kind == K_ACCEL) begin
                            r_next.rep_seq = r_reg.rep_seq + 8'd1; // RQ15
                        end
                        if (r_reg.kind == K_VS) begin
                            r_next.vs_idx = r_reg.vs_idx + 8'd1;
                        end
                    end
                end
            end
            default: r_next.state = ST_BOOT;
        endcase

        // after the case, so a flag set this cycle beats its clear
        // microsecond tick drives the report and vector timers
        r_next.us_div = r_reg.us_div + 6'd1;
        if (r_reg.us_div == 6'(US_CYCLES - 1)) begin
            r_next.us_div = 6'd0;
            r_next.delta = r_reg.delta + 32'd1;
            if (r_reg.en) begin
                r_next.tmr = r_reg.tmr + 32'd1;
                if (r_reg.tmr >= r_reg.period - 32'd1) begin
                    r_next.tmr = 32'd0;
                    r_next.p_accel = 1'b1; // RQ12
                end
            end
            if (r_reg.serial_mode && r_reg.state != ST_BOOT) begin
                r_next.vs_tmr = r_reg.vs_tmr + 32'd1;
                if (r_reg.vs_tmr == 32'(VS_PERIOD_US - 1)) begin
                    r_next.vs_tmr = 32'd0;
                    r_next.p_vs = 1'b1; // RQ1
                end
            end
        end

        // latest sample and its age
        if (accel_valid) begin
            r_next.smp = {accel_z, accel_y, accel_x};
            r_next.smp_status = accel_status;
            r_next.delta = 32'd0;
        end

        if (sf_ok) begin
            r_next.period = grant_period(r_reg.rx_int); // RQ11
            r_next.en = (r_reg.rx_int != 32'h0); // RQ7
            r_next.tmr = 32'd0;
            r_next.p_accel = 1'b0;
            // every accepted command queues a response, even one that leaves this sensor's period unchanged
            r_next.p_fresp = 1'b1; // RQ10 RQ13
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // all-zero reset leaves every sensor disabled
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r_reg <= '0; // RQ2
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // message store and outputs
    // ------------------------------------------------------------
    shp_rom u_rom (
        .mclk(mclk),
        .rom(rom_bus.mem)
    );

    assign rom_bus.addr = r_reg.rom_addr;
    assign tx_valid = r_reg.tx_valid;
    assign tx_data = r_reg.tx_data;
    assign host_attention_n = ~r_reg.attn; // RQ3 RQ16
    assign sensor_enabled = r_reg.en;

endmodule : shp_framer
`default_nettype wire

// file: test/shp_props.sv
// port checker for the host protocol framer
`timescale 1ns/10ps
`default_nettype none
module shp_props (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic mode_strap,
    input wire logic host_addressed,
    input wire logic rx_valid,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic host_attention_n,
    input wire logic sensor_enabled
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic sent_reg;
    // marks that the first byte has left since reset
    always_ff @(posedge mclk) begin
        if (!rst_n) sent_reg <= 1'b0;
        else if (tx_valid && tx_ready) sent_reg <= 1'b1;
    end
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
        !tx_valid && host_attention_n && !sensor_enabled) else $error("outputs busy in reset");
    a_valid_holds: assert property (tx_valid && !tx_ready |=> tx_valid)
        else $error("byte withdrawn while stalled");
    a_data_holds: assert property (tx_valid && !tx_ready |=> $stable(tx_data))
        else $error("byte changed while stalled");
    a_attn_held: assert property (!host_addressed [*5] ##0 !host_attention_n |=>
        !host_attention_n) else $error("attention dropped unaddressed");
    a_attn_release: assert property ($rose(host_addressed) && !host_attention_n
        |-> ##[1:6] host_attention_n) else $error("attention not released");
    a_framed_quiet: assert property (!mode_strap && $rose(tx_valid) |-> host_attention_n)
        else $error("byte sent before host addressed");
    a_enable_cause: assert property ($changed(sensor_enabled) |-> $past(rx_valid))
        else $error("sensor state changed unprompted");
    a_first_byte: assert property (tx_valid && !sent_reg |->
        tx_data == (mode_strap ? 8'h25 : 8'h0c)) else $error("wrong first byte");
    a_serial_off: assert property (mode_strap |-> !sensor_enabled)
        else $error("sensor on in vector mode");
    c_enable: cover property ($rose(sensor_enabled));
    c_stall: cover property (tx_valid && !tx_ready);
    c_serial: cover property (mode_strap && tx_valid && tx_ready);
endmodule : shp_props
bind shp_framer shp_props props_i (.mclk(mclk), .rst_n(rst_n), .mode_strap(mode_strap),
    .host_addressed(host_addressed), .rx_valid(rx_valid), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .host_attention_n(host_attention_n),
    .sensor_enabled(sensor_enabled));
`default_nettype wire

// file: test/shp_host_model.sv
// host processor model: answers attention and sinks framer bytes
`timescale 1ns/10ps
`default_nettype none
module shp_host_model (
    input wire logic mclk,
    input wire logic slow,
    input wire logic host_attention_n,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic host_addressed,
    output logic tx_ready
);
    logic [7:0] got[$];
    logic [1:0] ph = 2'b00;
    initial host_addressed = 1'b0;
    initial tx_ready = 1'b0;
    // slow host stalls three edges of four, so held bytes get exercised
    always @(posedge mclk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        ph <= ph + 2'd1;
        tx_ready <= #1 !slow || (ph == 2'b11);
        host_addressed <= #1 !host_attention_n;
    end
endmodule : shp_host_model
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the host protocol framer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import shp_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, mode_strap = 1'b0, rx_valid = 1'b0, slow = 1'b1;
    logic accel_valid = 1'b0, host_addressed, tx_valid, tx_ready, host_attention_n;
    logic sensor_enabled;
    logic [7:0] rx_data = 8'h00, tx_data, accel_status = 8'h03, seq_reg = 8'h01;
    logic [15:0] accel_x = 16'h1234, accel_y = 16'h5678, accel_z = 16'h9abc;
    int failures = 0, n_checks = 0, cycles = 0;
    shp_framer #(.STARTUP_CYCLES(20)) shp_framer_i (.mclk, .rst_n, .mode_strap,
        .host_addressed, .rx_valid, .rx_data, .tx_valid, .tx_ready, .tx_data,
        .host_attention_n, .accel_valid, .accel_x, .accel_y, .accel_z, .accel_status,
        .sensor_enabled);
    shp_host_model shp_host_model_i (.mclk, .slow, .host_attention_n, .tx_valid, .tx_data,
        .host_addressed, .tx_ready);
    always #12.5 mclk = ~mclk;
    // sample pulses and a watchdog far above the roughly twelve hundred cycles needed
    always @(posedge mclk) begin
        cycles++;
        accel_valid <= #1 (cycles % 50 == 0);
        if (cycles == 10000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    function automatic logic [7:0] g(input int i);
        return shp_host_model_i.got[i];
    endfunction : g
    task automatic hdr(input int b, input logic [7:0] len, ch, sq);
        chk({g(b), g(b + 1), g(b + 2), g(b + 3)} === {len, 8'h00, ch, sq}, "header");
    endtask : hdr
    // bounded wait, then a quiet spell proves nothing further follows
    task automatic wait_n(input int n, input string m);
        for (int i = 0; i < 2000 && shp_host_model_i.got.size() < n; i++) tick(1);
        tick(60);
        chk(shp_host_model_i.got.size() == n, m);
    endtask : wait_n
    task automatic restart(input logic mode);
        rst_n = 1'b0;
        mode_strap = mode;
        tick(5);
        rst_n = 1'b1;
        tick(1);
        chk(host_attention_n === 1'b1 && tx_valid === 1'b0, "reset outputs");
        shp_host_model_i.got.delete();
    endtask : restart
    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task automatic send_sf(input logic [7:0] id, input logic [31:0] us);
        logic [7:0] pk [21];
        pk = '{default: 8'h00};
        pk[0] = LEN_SET_FEATURE;
        pk[2] = CH_HUB;
        pk[4] = id;
        pk[5] = RID_ACCEL;
        {pk[12], pk[11], pk[10], pk[9]} = us;
        foreach (pk[i]) begin
            rx_valid = 1'b1;
            rx_data = pk[i];
            tick(1);
        end
        rx_valid = 1'b0;
    endtask : send_sf
    task automatic t_startup();
        restart(1'b0);
        wait_n(25, "startup bytes");
        hdr(0, 8'd12, CH_CTRL, 8'h00);
        hdr(12, 8'd5, CH_EXEC, 8'h00);
        hdr(17, 8'd8, CH_HUB, 8'h00);
        chk(sensor_enabled === 1'b0 && host_attention_n === 1'b1, "idle state");
    endtask : t_startup
    task automatic t_feature(input logic [7:0] id, input logic [31:0] req, gnt, input logic en);
        int b;
        b = shp_host_model_i.got.size();
        send_sf(id, req);
        if (id === RID_SET_FEATURE) begin
            wait_n(b + 21, "response bytes");
            hdr(b, 8'd21, CH_HUB, seq_reg);
            seq_reg++;
            chk(g(b + 4) === RID_FEATURE_RESP, "response id");
            chk({g(b + 12), g(b + 11), g(b + 10), g(b + 9)} === gnt, "granted period");
        end else begin
            wait_n(b, "ignored command");
        end
        chk(sensor_enabled === en, "sensor enable");
    endtask : t_feature
    task automatic t_serial();
        string s;
        s = "%sensor hub SW Ver 3.2\r\n";
        restart(1'b1);
        wait_n(24, "banner bytes");
        for (int i = 0; i < 24; i++) chk(g(i) === s[i], "banner text");
        send_sf(RID_SET_FEATURE, 32'd5000);
        tick(40);
        chk(sensor_enabled === 1'b0 && shp_host_model_i.got.size() == 24, "host ignored");
    endtask : t_serial
    initial begin
        t_startup();
        slow = 1'b0;
        t_feature(RID_SET_FEATURE, 32'd60000, 32'd80000, 1'b1);
        t_feature(8'hfe, 32'd2500, 32'd0, 1'b1);
        t_feature(RID_SET_FEATURE, 32'd200000, 32'd160000, 1'b1);
        t_feature(RID_SET_FEATURE, 32'd2500, 32'd2500, 1'b1);
        t_feature(RID_SET_FEATURE, 32'd0, 32'd0, 1'b0);
        slow = 1'b1;
        t_serial();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
